// ### rtl/dfe_front_end.sv
// Digital front end of a 12-bit voltage-output converter channel
//
// Overview of operation
// (RL1) Byte right port: written bits 7:0 go to holding bits 11:4.
// (RL2) Word left port: written bits 15:4 go to holding bits 11:0.
// (RL3) Word right port: written bits 11:0 go to holding unshifted.
// (RL4) Holding register has no address; set only through the data ports.
// (RL5) Holding moves to output automatically, by software or external trigger.
// (RL6) Power-on bit drives analog only; digital path always works.
// (RL7) Buffer-off control bit drives the output buffer control line.
// (RL8) Power-on set routes the shared pin to the converter output.
// (RL9) Data path is 12 bits; 8-bit and left/right 12-bit input modes.
// (RL10) Trigger disabled: output loads one cycle after the port write.
// (RL11) Hardware trigger: output loads three cycles after the trigger.
// (RL12) Software trigger bit self-clears once the output is loaded.
// (RL13) Software never writes the output register directly.
// (RL14) Reset clears holding, output, power-on and buffer-off bits.
`default_nettype none
module dfe_front_end
    import dfe_pkg::*;
#(
    parameter int DATA_W = 12
) (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rst_n,
    // Register port
    input  wire logic [7:0]        reg_addr,
    input  wire logic [31:0]       reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output var  logic [31:0]       reg_rdata,
    // External trigger sources (asynchronous)
    input  wire logic              timer_trig,
    input  wire logic              pin_trig,
    // Analog macrocell controls
    output var  logic [DATA_W-1:0] output_register,
    output var  logic              channel_power_on,
    output var  logic              buffer_off,
    output var  logic              pin_route_en
);
    // ------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------
    logic [1:0] rst_sync_r;
    logic       rst_int_n;

    // Two-stage release of the asynchronous reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_sync_r <= 2'h0;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_int_n = rst_sync_r[1];

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        dfe_ctrl_type      ctrl;
        logic              software_trigger;
        logic [DATA_W-1:0] hold;
        logic [DATA_W-1:0] dout;
        logic              auto_ld;
        logic [1:0]        tim_sy;
        logic [1:0]        pin_sy;
        logic              tim_d;
        logic              pin_d;
        logic [31:0]       rdata;
        logic              route;
    } dfe_state_type;

    dfe_state_type st_r;
    dfe_state_type st_nxt;
    dfe_bus_type   bus;
    logic          hw_edge;
    logic          hw_load;

    assign bus = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

    // ------------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------------
    // Rising-edge detect on a synchronised level
    function automatic logic rise(input logic now, input logic prev);
        rise = now & ~prev;
    endfunction : rise

    // Zero-extend a 12-bit value to the bus width
    function automatic logic [31:0] ext(input logic [DATA_W-1:0] v);
        ext = {{(32 - DATA_W){1'b0}}, v};
    endfunction : ext

    // Hardware trigger edge of the selected source, only with triggers on
    always_comb begin
        hw_edge = 1'b0;
        if (st_r.ctrl.trigger_enable) begin
            if (st_r.ctrl.tsel == DFE_TSEL_TIMER) begin
                hw_edge = rise(st_r.tim_sy[1], st_r.tim_d);
            end else if (st_r.ctrl.tsel == DFE_TSEL_PIN) begin
                hw_edge = rise(st_r.pin_sy[1], st_r.pin_d);
            end
        end
    end

    // Three-cycle delay from hardware trigger to output load
    dfe_trig_delay #(
        .LAT       (DFE_HW_TRIG_LAT)
    ) u_trig_delay (
        .clk       (clk),
        .rst_n     (rst_int_n),
        .pulse_in  (hw_edge),
        .pulse_out (hw_load)
    ); // [RL11]

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        st_nxt.auto_ld = 1'b0;
        st_nxt.rdata = 32'h0000_0000;
        // Synchronisers; first stage feeds only the second
        st_nxt.tim_sy = {st_r.tim_sy[0], timer_trig};
        st_nxt.pin_sy = {st_r.pin_sy[0], pin_trig};
        st_nxt.tim_d = st_r.tim_sy[1];
        st_nxt.pin_d = st_r.pin_sy[1];

        // Output load: digital path works regardless of power-on [RL6]
        if (st_r.auto_ld && !st_r.ctrl.trigger_enable) begin
            st_nxt.dout = st_r.hold; // [RL5] [RL10]
        end else if (hw_load) begin
            st_nxt.dout = st_r.hold; // [RL5] [RL11]
        end else if (st_r.software_trigger) begin
            st_nxt.dout = st_r.hold; // [RL5]
            st_nxt.software_trigger = 1'b0; // [RL12]
        end

        // Register writes; holding reachable only via the data ports [RL4]
        if (bus.wr) begin
            if (bus.addr == DFE_CTRL_OFS) begin
                st_nxt.ctrl.channel_power_on = bus.wdata[DFE_EN_BIT];
                st_nxt.ctrl.buffer_off = bus.wdata[DFE_BOFF_BIT]; // [RL7]
                st_nxt.ctrl.trigger_enable = bus.wdata[DFE_TEN_BIT];
                // Trigger select frozen while channel powered
                if (!st_r.ctrl.channel_power_on) begin
                    st_nxt.ctrl.tsel = bus.wdata[DFE_TSEL_LO +: 3];
                end
            end else if (bus.addr == DFE_SOFTWARE_TRIGGER_OFS) begin
                // Honoured only with software source selected
                if (bus.wdata[0] && st_r.ctrl.trigger_enable
                        && st_r.ctrl.tsel == DFE_TSEL_SW) begin
                    st_nxt.software_trigger = 1'b1;
                end
            end else if (bus.addr == DFE_BYTE_RIGHT_OFS) begin
                st_nxt.hold = {bus.wdata[7:0], 4'h0}; // [RL1] [RL9]
                st_nxt.auto_ld = 1'b1;
            end else if (bus.addr == DFE_WORD_LEFT_OFS) begin
                st_nxt.hold = bus.wdata[15:4]; // [RL2] [RL9]
                st_nxt.auto_ld = 1'b1;
            end else if (bus.addr == DFE_WORD_RIGHT_OFS) begin
                st_nxt.hold = bus.wdata[11:0]; // [RL3] [RL9]
                st_nxt.auto_ld = 1'b1;
            end
            // Output offset is read-only; writes ignored [RL13]
        end

        // Register reads; unmapped addresses return zero
        if (bus.rd) begin
            if (bus.addr == DFE_CTRL_OFS) begin
                st_nxt.rdata = {26'h0, st_r.ctrl};
            end else if (bus.addr == DFE_SOFTWARE_TRIGGER_OFS) begin
                st_nxt.rdata = {31'h0, st_r.software_trigger};
            end else if (bus.addr == DFE_BYTE_RIGHT_OFS) begin
                st_nxt.rdata = {24'h0, st_r.hold[11:4]};
            end else if (bus.addr == DFE_WORD_LEFT_OFS) begin
                st_nxt.rdata = {16'h0, st_r.hold, 4'h0};
            end else if (bus.addr == DFE_WORD_RIGHT_OFS) begin
                st_nxt.rdata = ext(st_r.hold);
            end else if (bus.addr == DFE_OUTPUT_OFS) begin
                st_nxt.rdata = ext(st_r.dout);
            end
        end

        // Pin routing follows the power-on bit
        st_nxt.route = st_nxt.ctrl.channel_power_on; // [RL8]
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_int_n) begin
        if (!rst_int_n) begin
            st_r <= '0; // [RL14]
            st_r.hold <= DFE_DATA_RST;
            st_r.dout <= DFE_DATA_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs straight from flip-flops
    assign reg_rdata = st_r.rdata;
    assign output_register = st_r.dout;
    assign channel_power_on = st_r.ctrl.channel_power_on;
    assign buffer_off = st_r.ctrl.buffer_off; // [RL7]
    assign pin_route_en = st_r.route; // [RL8]
endmodule : dfe_front_end
`default_nettype wire

// ### rtl/dfe_pkg.sv
// Package: register map, field layout and timing for the converter front end
`default_nettype none
package dfe_pkg;
    // Register offsets (byte addresses)
    localparam logic [7:0] DFE_CTRL_OFS       = 8'h00;
    localparam logic [7:0] DFE_SOFTWARE_TRIGGER_OFS     = 8'h04;
    localparam logic [7:0] DFE_BYTE_RIGHT_OFS = 8'h10;
    localparam logic [7:0] DFE_WORD_LEFT_OFS  = 8'h0C;
    localparam logic [7:0] DFE_WORD_RIGHT_OFS = 8'h08;
    localparam logic [7:0] DFE_OUTPUT_OFS     = 8'h2C;
    // Control field positions
    localparam int DFE_EN_BIT   = 0;
    localparam int DFE_BOFF_BIT = 1;
    localparam int DFE_TEN_BIT  = 2;
    localparam int DFE_TSEL_LO  = 3;
    // Trigger select codes
    localparam logic [2:0] DFE_TSEL_TIMER = 3'h3;
    localparam logic [2:0] DFE_TSEL_PIN   = 3'h6;
    localparam logic [2:0] DFE_TSEL_SW    = 3'h7;
    // Reset values
    localparam logic [11:0] DFE_DATA_RST = 12'h000;
    // Cycles from hardware trigger to output load
    localparam int DFE_HW_TRIG_LAT = 3;

    // Control register contents
    typedef struct packed {
        logic [2:0] tsel;
        logic       trigger_enable;
        logic       buffer_off;
        logic       channel_power_on;
    } dfe_ctrl_type;
    // Register bus request
    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } dfe_bus_type;
endpackage : dfe_pkg
`default_nettype wire

// ### rtl/dfe_trig_delay.sv
// Trigger delay line: shifts a trigger pulse by a fixed cycle count
`default_nettype none
module dfe_trig_delay
    import dfe_pkg::*;
#(
    parameter int LAT = DFE_HW_TRIG_LAT
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // Pulses
    input  wire logic pulse_in,
    output var  logic pulse_out
);
    typedef struct packed {
        logic [LAT-1:0] sh;
    } dfe_dly_type;
    dfe_dly_type st_r;
    dfe_dly_type st_nxt;

    // Shift chain
    always_comb begin
        st_nxt = st_r;
        st_nxt.sh = {st_r.sh[LAT-2:0], pulse_in};
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign pulse_out = st_r.sh[LAT-1];
endmodule : dfe_trig_delay
`default_nettype wire

// ### verification/dfe_front_end_props.sv
// Port checker for the converter front end
`default_nettype none
module dfe_front_end_props
    import dfe_pkg::*;
#(
    parameter int DATA_W = 12
) (
    // Clock and reset
    input wire logic              clk,
    input wire logic              rst_n,
    // Register port
    input wire logic [7:0]        reg_addr,
    input wire logic [31:0]       reg_wdata,
    input wire logic              reg_wr,
    input wire logic              reg_rd,
    input wire logic [31:0]       reg_rdata,
    // Triggers and converter controls
    input wire logic              timer_trig,
    input wire logic              pin_trig,
    input wire logic [DATA_W-1:0] output_register,
    input wire logic              channel_power_on,
    input wire logic              buffer_off,
    input wire logic              pin_route_en
);
    // ------------------------------------------------------------
    // Shadow state and properties
    // ------------------------------------------------------------
    logic        ten_q;
    logic [2:0]  tsel_q;
    logic [11:0] hold_q;
    logic        wc;
    logic        w8;
    logic        wl;
    logic        wrt;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Decoded writes
    assign wc  = reg_wr && reg_addr == DFE_CTRL_OFS;
    assign w8  = reg_wr && reg_addr == DFE_BYTE_RIGHT_OFS;
    assign wl  = reg_wr && reg_addr == DFE_WORD_LEFT_OFS;
    assign wrt = reg_wr && reg_addr == DFE_WORD_RIGHT_OFS;
    // Trigger setup and holding value as software last set them
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ten_q <= 1'b0;
            tsel_q <= 3'h0;
            hold_q <= 12'h000;
        end else begin
            if (wc) begin
                ten_q <= reg_wdata[DFE_TEN_BIT];
                tsel_q <= channel_power_on ? tsel_q : reg_wdata[5:3];
            end
            hold_q <= w8 ? {reg_wdata[7:0], 4'h0} : wl ? reg_wdata[15:4]
                    : wrt ? reg_wdata[11:0] : hold_q;
        end
    end
    a_route_follows_en: assert property (pin_route_en == channel_power_on)
        else $error("pin route differs from power bit");
    a_power_bit_wr: assert property (wc |=> channel_power_on == $past(reg_wdata[0]))
        else $error("power bit not taken from control write");
    a_boff_bit_wr: assert property (wc |=> buffer_off == $past(reg_wdata[1]))
        else $error("buffer control not taken from control write");
    a_byte_auto_load: assert property (w8 && !ten_q |-> ##2 output_register == {$past(reg_wdata[7:0], 2), 4'h0})
        else $error("byte port sample not loaded");
    a_left_auto_load: assert property (wl && !ten_q |-> ##2 output_register == $past(reg_wdata[15:4], 2))
        else $error("left port sample not loaded");
    a_right_auto_load: assert property (wrt && !ten_q |-> ##2 output_register == $past(reg_wdata[11:0], 2))
        else $error("right port sample not loaded");
    a_ten_holds_out: assert property (wrt && ten_q |-> ##1 $stable(output_register) [*2])
        else $error("output moved without a trigger");
    a_sw_trig_load: assert property (reg_wr && reg_addr == DFE_SOFTWARE_TRIGGER_OFS && reg_wdata[0] && ten_q && tsel_q == DFE_TSEL_SW |-> ##2 output_register == hold_q)
        else $error("software trigger did not load output");
    a_pin_trig_load: assert property ($rose(pin_trig) && ten_q && tsel_q == DFE_TSEL_PIN |-> ##[4:8] output_register == hold_q)
        else $error("pin trigger did not load output");
    c_byte_auto: cover property (w8 && !ten_q);
    c_sw_trig: cover property (reg_wr && reg_addr == DFE_SOFTWARE_TRIGGER_OFS && ten_q);
    c_timer_trig: cover property ($rose(timer_trig) && ten_q);
endmodule : dfe_front_end_props
bind dfe_front_end dfe_front_end_props #(.DATA_W(DATA_W)) u_props (
    .clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .timer_trig, .pin_trig, .output_register, .channel_power_on,
    .buffer_off, .pin_route_en
);
`default_nettype wire

// ### verification/testbench.sv
// Self-checking bench for the converter front end
`default_nettype none
module testbench
    import dfe_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // Stimulus, model and checks
    // ------------------------------------------------------------
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic        timer_trig = 1'b0;
    logic        pin_trig = 1'b0;
    logic [31:0] reg_rdata;
    logic [11:0] output_register;
    logic        channel_power_on;
    logic        buffer_off;
    logic        pin_route_en;
    int          fail_count = 0;
    int          checks_done = 0;
    int          seed = 27007;
    int          hold = 0;
    // Clock at 250 MHz
    always #2 clk = ~clk;
    dfe_front_end DUT (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .timer_trig, .pin_trig, .output_register,
        .channel_power_on, .buffer_off, .pin_route_en);
    task automatic stop_test;
        if (fail_count == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : stop_test
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : cmp
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 cmp(reg_rdata, e);
    endtask : rd
    // Port write with the model's alignment shift
    task automatic dwr(input int p, input logic [31:0] d);
        hold = p == 0 ? {d[7:0], 4'h0} : p == 1 ? d[15:4] : d[11:0];
        wr(p == 0 ? DFE_BYTE_RIGHT_OFS : p == 1 ? DFE_WORD_LEFT_OFS
            : DFE_WORD_RIGHT_OFS, d);
    endtask : dwr
    // External trigger: count edges until the output takes the sample
    task automatic hw(input logic [2:0] sel);
        int old;
        int k;
        wr(DFE_CTRL_OFS, {26'h0, sel, 3'h4});
        old = hold;
        dwr(2, $random(seed));
        cyc(3);
        cmp(output_register, old);
        @(posedge clk);
        pin_trig <= sel == DFE_TSEL_PIN;
        timer_trig <= sel == DFE_TSEL_TIMER;
        for (k = 0; k < 12 && output_register !== 12'(hold); k++) cyc(1);
        cmp(k >= 4 && k <= 8, 1);
        cmp(output_register, hold);
        pin_trig <= 1'b0;
        timer_trig <= 1'b0;
    endtask : hw
    // Main sequence
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        cyc(3);
        cmp({output_register, channel_power_on, buffer_off}, 0);
        rd(DFE_CTRL_OFS, 0);
        wr(DFE_CTRL_OFS, 32'h3);
        cyc(1);
        cmp({channel_power_on, buffer_off, pin_route_en}, 7);
        for (int i = 0; i < 30; i++) begin
            dwr(i % 3, $random(seed));
            if (i[0]) begin
                cyc(2);
                cmp(output_register, hold);
            end
        end
        wr(DFE_OUTPUT_OFS, ~hold);
        cyc(2);
        cmp(output_register, hold);
        rd(DFE_OUTPUT_OFS, hold);
        rd(DFE_WORD_RIGHT_OFS, hold);
        rd(8'h20, 0);
        wr(DFE_CTRL_OFS, 0);
        cyc(1);
        cmp({channel_power_on, pin_route_en}, 0);
        wr(DFE_CTRL_OFS, 32'h3C);
        dwr(0, $random(seed));
        wr(DFE_SOFTWARE_TRIGGER_OFS, 1);
        cyc(2);
        cmp(output_register, hold);
        rd(DFE_SOFTWARE_TRIGGER_OFS, 0);
        hw(DFE_TSEL_PIN);
        hw(DFE_TSEL_TIMER);
        stop_test();
    end
    // Watchdog
    initial begin
        #100000;
        fail_count++;
        stop_test();
    end
endmodule : testbench
`default_nettype wire
